// ===== verilog/nibble_cpu_map.vh
`ifndef NIBBLE_CPU_MAP_VH
`define NIBBLE_CPU_MAP_VH

// Datapath widths
`define ACC_W          4
`define COL_W          4
`define ROW_W          3
`define PTR_W          7
`define RAM_DEPTH      128

// Opcodes, single byte except OP_LDI
`define OP_LI_HI       4'h9
`define OP_LDZ_HI      4'h8
`define OP_LM_HI6      6'h0e
`define OP_XM_HI6      6'h0a
`define OP_XMI_HI6     6'h0f
`define OP_XMD_HI6     6'h0b
`define OP_LDI         8'h15
`define OP_STORE       8'h02
`define OP_TAL         8'h07
`define OP_TLA         8'h12
`define OP_AD          8'h08
`define OP_ADC         8'h19
`define OP_ADS         8'h09
`define OP_DAA         8'h06
`define OP_DAS         8'h0a
`define OP_EXL         8'h18
`define OP_CMA         8'h10
`define OP_CIA         8'h11
`define OP_CLC         8'h0b
`define OP_STC         8'h1b
`define OP_TC          8'h04
`define OP_INC         8'h0d
`define OP_DEC         8'h0f
`define OP_IND         8'h33
`define OP_DED         8'h13

// Other two-byte opcodes, needed only to skip over them whole
`define OP_CI          8'h17
`define OP_CLI         8'h16
`define OP_JMPCAL_HI4  4'ha

// Decimal adjust addends
`define BCD_SUM_ADD    4'h6
`define BCD_DIFF_ADD   4'ha

// APB register byte offsets
`define REG_CTRL       12'h000
`define REG_STATE      12'h004

// Control register fields and reset value
`define CTRL_RUN_BIT   0
`define CTRL_RESET     1'b1

// State register field positions
`define ST_ACC_LSB     0
`define ST_CARRY_BIT   4
`define ST_COL_LSB     8
`define ST_ROW_LSB     12
`define ST_RUN_BIT     16
`define ST_WAIT_BIT    17
`define ST_SKIP_BIT    18

`endif

// ===== verilog/nibble_ram.v
`timescale 1ns/1ps

// Nibble RAM: synchronous write, registered read with write forwarding
module nibble_ram (
  input  wire       clock,
  input  wire       rst_sync_b,
  input  wire [6:0] raddr,
  output reg  [3:0] rdata,
  input  wire       we,
  input  wire [6:0] waddr,
  input  wire [3:0] wdata
);

  reg [3:0] mem [0:127];    // Storage, not reset

  // Write port
  always @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read port; forwarding keeps the read copy fresh when the same word is written
  always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rdata <= 4'h0;
    end else if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ===== verilog/nibble_cpu_data_ops.v
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "nibble_cpu_map.vh"

module nibble_cpu_data_ops (
  input  wire        clock,
  input  wire        rst_b,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Instruction byte stream from the sequencer
  input  wire        instr_valid,
  input  wire [7:0]  instr_byte,
  output wire        instr_ready,
  // Visible machine state
  output reg  [3:0]  acc_r,
  output reg         carry_r,
  output reg  [2:0]  pointer_row_r,
  output reg  [3:0]  pointer_column_r,
  output reg         skip_taken_r
);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  localparam ST_EXEC     = 2'd0;  // Next byte is an opcode
  localparam ST_IMM      = 2'd1;  // Next byte is the pointer-set operand
  localparam ST_SKIP     = 2'd2;  // Next byte is an opcode to pass over
  localparam ST_SKIP_IMM = 2'd3;  // Next byte is the second byte of a skipped opcode

  reg        rst_meta_r;          // Reset release, first stage
  reg        rst_sync_r;          // Reset release, used by all logic
  reg [1:0]  state_r;             // Sequencer state
  reg [1:0]  state_nxt;
  reg        run_en_r;            // Software run enable
  reg        string_r;            // Last executed opcode was a run-type load
  reg        string_nxt;
  reg [3:0]  acc_nxt;
  reg        carry_nxt;
  reg [2:0]  row_nxt;
  reg [3:0]  col_nxt;
  reg        skip_cond;           // Current opcode asks to skip its follower
  reg        ram_we;
  reg [3:0]  ram_wdata;
  wire [3:0] ram_rd;              // Nibble at the current pointer
  wire       fire;                // A byte is taken this cycle
  wire [4:0] sum_plain;
  wire [4:0] sum_carry;
  wire       apb_setup;
  wire       apb_write;
  wire       addr_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Byte count of any opcode, so a skip consumes the whole instruction
  function two_byte;
    input [7:0] op;
    begin
      two_byte = (op == `OP_LDI) || (op == `OP_CI) || (op == `OP_CLI) ||
                 (op[7:4] == `OP_JMPCAL_HI4);
    end
  endfunction

  // Run-type opcodes: immediate load, of which the clear is the zero case
  function run_type;
    input [7:0] op;
    begin
      run_type = (op[7:4] == `OP_LI_HI);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release synchroniser
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction handshake; stalling via run enable holds the sequencer
  assign instr_ready = run_en_r;
  assign fire        = instr_valid & run_en_r;

  // Nibble-wide sums; bit 4 is the carry out of bit 3
  assign sum_plain = {1'b0, acc_r} + {1'b0, ram_rd};
  assign sum_carry = {1'b0, acc_r} + {1'b0, ram_rd} + {4'h0, carry_r};

  ////////////////////////////////////////////////////////////////////////////////
  // Execute: next acc, carry, pointer, run-load flag, sequencer state and RAM write
  always @* begin
    acc_nxt    = acc_r;
    carry_nxt  = carry_r;
    row_nxt    = pointer_row_r;
    col_nxt    = pointer_column_r;
    skip_cond  = 1'b0;
    ram_we     = 1'b0;
    ram_wdata  = acc_r;
    string_nxt = string_r;
    state_nxt  = state_r;
    if (fire) begin
      case (state_r)
        ST_IMM: begin
          // Second byte of the pointer set
          {row_nxt, col_nxt} = instr_byte[6:0];
          string_nxt         = 1'b0;
          state_nxt          = ST_EXEC;
        end
        ST_SKIP: begin
          // Pass over the opcode and, if it has one, its operand byte
          string_nxt = 1'b0;
          state_nxt  = two_byte(instr_byte) ? ST_SKIP_IMM : ST_EXEC;
        end
        ST_SKIP_IMM: begin
          state_nxt = ST_EXEC;
        end
        ST_EXEC: begin
          string_nxt = run_type(instr_byte);
          if (instr_byte[7:4] == `OP_LI_HI) begin
            // Only the first load of a run takes effect
            if (!string_r) begin
              acc_nxt = instr_byte[3:0];
            end
          end else if (instr_byte[7:4] == `OP_LDZ_HI) begin
            row_nxt = 3'h0;
            col_nxt = instr_byte[3:0];
          end else if (instr_byte[7:2] == `OP_LM_HI6) begin
            acc_nxt = ram_rd;
            row_nxt = pointer_row_r ^ {1'b0, instr_byte[1:0]};
          end else if (instr_byte[7:2] == `OP_XM_HI6) begin
            acc_nxt = ram_rd;
            ram_we  = 1'b1;
            row_nxt = pointer_row_r ^ {1'b0, instr_byte[1:0]};
          end else if (instr_byte[7:2] == `OP_XMI_HI6) begin
            acc_nxt   = ram_rd;
            ram_we    = 1'b1;
            row_nxt   = pointer_row_r ^ {1'b0, instr_byte[1:0]};
            col_nxt   = pointer_column_r + 4'h1;
            skip_cond = (pointer_column_r == 4'hf);
          end else if (instr_byte[7:2] == `OP_XMD_HI6) begin
            acc_nxt   = ram_rd;
            ram_we    = 1'b1;
            row_nxt   = pointer_row_r ^ {1'b0, instr_byte[1:0]};
            col_nxt   = pointer_column_r - 4'h1;
            skip_cond = (pointer_column_r == 4'h0);
          end else begin
            case (instr_byte)
              `OP_LDI: begin
                state_nxt = ST_IMM;
              end
              `OP_STORE: begin
                ram_we = 1'b1;
              end
              `OP_TAL: begin
                col_nxt = acc_r;
              end
              `OP_TLA: begin
                acc_nxt = pointer_column_r;
              end
              `OP_AD: begin
                acc_nxt   = sum_plain[3:0];
                skip_cond = sum_plain[4];
              end
              `OP_ADC: begin
                acc_nxt = sum_carry[3:0];
                if (sum_carry[4]) begin
                  carry_nxt = 1'b1;
                end
              end
              `OP_ADS: begin
                acc_nxt = sum_carry[3:0];
                if (sum_carry[4]) begin
                  carry_nxt = 1'b1;
                  skip_cond = 1'b1;
                end
              end
              `OP_DAA: begin
                acc_nxt = acc_r + `BCD_SUM_ADD;
              end
              `OP_DAS: begin
                acc_nxt = acc_r + `BCD_DIFF_ADD;
              end
              `OP_EXL: begin
                acc_nxt = acc_r ^ ram_rd;
              end
              `OP_CMA: begin
                acc_nxt = ~acc_r;
              end
              `OP_CIA: begin
                acc_nxt = ~acc_r + 4'h1;
              end
              `OP_CLC: begin
                carry_nxt = 1'b0;
              end
              `OP_STC: begin
                carry_nxt = 1'b1;
              end
              `OP_TC: begin
                skip_cond = carry_r;
              end
              `OP_INC: begin
                acc_nxt   = acc_r + 4'h1;
                skip_cond = (acc_r == 4'hf);
              end
              `OP_DEC: begin
                acc_nxt   = acc_r - 4'h1;
                skip_cond = (acc_r == 4'h0);
              end
              `OP_IND: begin
                col_nxt   = pointer_column_r + 4'h1;
                skip_cond = (pointer_column_r == 4'hf);
              end
              `OP_DED: begin
                col_nxt   = pointer_column_r - 4'h1;
                skip_cond = (pointer_column_r == 4'h0);
              end
              default: begin
                // Opcodes of other groups execute as no-operations here
                state_nxt = ST_EXEC;
              end
            endcase
          end
          if (skip_cond) begin
            state_nxt = ST_SKIP;
          end
        end
        default: begin
          state_nxt = ST_EXEC;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Architectural state
  always @(posedge clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      acc_r            <= 4'h0;
      carry_r          <= 1'b0;
      pointer_row_r    <= 3'h0;
      pointer_column_r <= 4'h0;
      string_r         <= 1'b0;
      state_r          <= ST_EXEC;
      skip_taken_r     <= 1'b0;
    end else begin
      acc_r            <= acc_nxt;
      carry_r          <= carry_nxt;
      pointer_row_r    <= row_nxt;
      pointer_column_r <= col_nxt;
      string_r         <= string_nxt;
      state_r          <= state_nxt;
      // One-cycle pulse when an opcode decides to skip its follower
      skip_taken_r     <= fire && (state_r == ST_EXEC) && skip_cond;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // RAM; reading at the next pointer keeps ram_rd at the pointed nibble
  // every cycle, so all memory operations finish in a single cycle
  nibble_ram u_ram (
    .clock      (clock),
    .rst_sync_b (rst_sync_r),
    .raddr      ({row_nxt, col_nxt}),
    .rdata      (ram_rd),
    .we         (ram_we),
    .waddr      ({pointer_row_r, pointer_column_r}),
    .wdata      (ram_wdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped offsets
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite;
  assign addr_ok   = (paddr == `REG_CTRL) || (paddr == `REG_STATE);
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~addr_ok;

  // Control register write; clearing run stalls the instruction stream
  always @(posedge clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      run_en_r <= `CTRL_RESET;
    end else if (apb_write && (paddr == `REG_CTRL)) begin
      run_en_r <= pwdata[`CTRL_RUN_BIT];
    end
  end

  // Read data captured in the setup cycle, stable through the access cycle
  always @(posedge clock or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata <= 32'h0000_0000;
      if (paddr == `REG_CTRL) begin
        prdata[`CTRL_RUN_BIT] <= run_en_r;
      end else if (paddr == `REG_STATE) begin
        prdata[`ST_ACC_LSB+3:`ST_ACC_LSB] <= acc_r;
        prdata[`ST_CARRY_BIT]             <= carry_r;
        prdata[`ST_COL_LSB+3:`ST_COL_LSB] <= pointer_column_r;
        prdata[`ST_ROW_LSB+2:`ST_ROW_LSB] <= pointer_row_r;
        prdata[`ST_RUN_BIT]               <= string_r;
        prdata[`ST_WAIT_BIT]              <= (state_r == ST_IMM);
        prdata[`ST_SKIP_BIT]              <= state_r[1];
      end
    end
  end

endmodule

// ===== verification/nibble_cpu_data_ops_checker.sv
`timescale 1ns/1ps
`include "nibble_cpu_map.vh"

module nibble_cpu_data_ops_checker (
  input wire        clock,
  input wire        rst_b,
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire        pslverr,
  input wire        instr_valid,
  input wire [7:0]  instr_byte,
  input wire        instr_ready,
  input wire [3:0]  acc_r,
  input wire        carry_r,
  input wire [3:0]  pointer_column_r,
  input wire        skip_taken_r
);
  ////////////////////////////////////////////////////////////////////////////////
  reg  [7:0] prev_b;  // Last byte the block took
  reg        prev_ok; // That byte was taken right after a plain opcode
  wire       take   = instr_valid && instr_ready;
  // A plain predecessor cannot skip, start a run or await an operand,
  // so the byte after it surely executes as an opcode
  wire       clean  = prev_b == 8'h00 || prev_b == `OP_CLC || prev_b == `OP_STC
                   || prev_b == `OP_CMA;
  wire       run_ok = take && clean;

  // Track the byte history seen on the stream
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prev_b  <= 8'h00;
      prev_ok <= 1'b1;
    end else if (take) begin
      prev_b  <= instr_byte;
      prev_ok <= clean;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_li; run_ok && instr_byte[7:4] == 4'h9 |=> acc_r == $past(instr_byte[3:0]); endproperty
  a_li: assert property (p_li) else $error("immediate load wrong");
  property p_li_run; take && prev_ok && prev_b[7:4] == 4'h9 && instr_byte[7:4] == 4'h9
    |=> $stable(acc_r); endproperty
  a_li_run: assert property (p_li_run) else $error("load in a run changed acc");
  property p_ldz; run_ok && instr_byte[7:4] == 4'h8 |=> pointer_column_r == $past(instr_byte[3:0]); endproperty
  a_ldz: assert property (p_ldz) else $error("page zero set wrong");
  property p_tal; run_ok && instr_byte == `OP_TAL |=> pointer_column_r == $past(acc_r); endproperty
  a_tal: assert property (p_tal) else $error("acc to column wrong");
  property p_inc; run_ok && instr_byte == `OP_INC |=> acc_r == $past(acc_r) + 4'h1
    && skip_taken_r == ($past(acc_r) == 4'hf); endproperty
  a_inc: assert property (p_inc) else $error("acc increment wrong");
  property p_ind; run_ok && instr_byte == `OP_IND |=> pointer_column_r == $past(pointer_column_r)
    + 4'h1 && skip_taken_r == ($past(pointer_column_r) == 4'hf); endproperty
  a_ind: assert property (p_ind) else $error("column step up wrong");
  property p_ded; run_ok && instr_byte == `OP_DED |=> pointer_column_r == $past(pointer_column_r)
    - 4'h1 && skip_taken_r == ($past(pointer_column_r) == 4'h0); endproperty
  a_ded: assert property (p_ded) else $error("column step down wrong");
  property p_carry; run_ok && (instr_byte == `OP_STC || instr_byte == `OP_CLC)
    |=> carry_r == $past(instr_byte[4]); endproperty
  a_carry: assert property (p_carry) else $error("carry set or clear wrong");
  property p_tc; run_ok && instr_byte == `OP_TC |=> skip_taken_r == $past(carry_r)
    && $stable(carry_r); endproperty
  a_tc: assert property (p_tc) else $error("carry test wrong");
  property p_skip; skip_taken_r && take && instr_byte[7:4] == 4'h9 |=> $stable(acc_r); endproperty
  a_skip: assert property (p_skip) else $error("skipped byte executed");
  property p_stall; !instr_ready |=> $stable(acc_r) && $stable(pointer_column_r); endproperty
  a_stall: assert property (p_stall) else $error("state moved while stopped");
  property p_slverr; psel && penable |-> pslverr == (paddr != `REG_CTRL && paddr != `REG_STATE);
  endproperty
  a_slverr: assert property (p_slverr) else $error("bus error flag wrong");
endmodule

bind nibble_cpu_data_ops nibble_cpu_data_ops_checker chk (
  .clock, .rst_b, .psel, .penable, .paddr, .pslverr, .instr_valid, .instr_byte,
  .instr_ready, .acc_r, .carry_r, .pointer_column_r, .skip_taken_r
);

// ===== verification/seq_model.sv
`timescale 1ns/1ps

module seq_model (
  input  wire logic       clock,
  input  wire logic       instr_ready,
  output logic            instr_valid,
  output logic [7:0]      instr_byte
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] q[$];     // Bytes still to be presented
  int         gap  = 0; // Idle cycles between bytes, models a slow fetch
  int         idle = 0; // Idle cycles spent since the last byte

  initial begin
    instr_valid = 1'b0;
    instr_byte  = 8'h00;
  end

  // Offer the next byte once the current one is taken; hold it while refused
  always @(posedge clock) begin
    if (!instr_valid || instr_ready) begin
      if (q.size() != 0 && idle >= gap) begin
        instr_valid <= 1'b1;
        instr_byte  <= q.pop_front();
        idle        <= 0;
      end else begin
        // Nothing offered: byte lines toggle so no stale value looks valid
        instr_valid <= 1'b0;
        instr_byte  <= ~instr_byte;
        idle        <= idle + 1;
      end
    end
  end
endmodule

// ===== verification/nibble_cpu_data_ops_tb.sv
`timescale 1ns/1ps
`include "nibble_cpu_map.vh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected at %0t got %h exp %h", $time, got, exp); end end

module nibble_cpu_data_ops_tb;
  typedef logic [7:0] prog_t[$]; // Byte stream for the sequencer
  logic        clock, rst_b, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic        er;
  wire  [31:0] prdata;
  wire         pready, pslverr, instr_valid, instr_ready, carry_r, skip_taken_r;
  wire  [7:0]  instr_byte;
  wire  [3:0]  acc_r, pointer_column_r;
  wire  [2:0]  pointer_row_r;
  int          fail_count = 0;
  int          comparisons = 0;

  nibble_cpu_data_ops DUT (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_valid(instr_valid), .instr_byte(instr_byte),
    .instr_ready(instr_ready), .acc_r(acc_r), .carry_r(carry_r),
    .pointer_row_r(pointer_row_r), .pointer_column_r(pointer_column_r),
    .skip_taken_r(skip_taken_r));
  seq_model SEQ (.clock(clock), .instr_ready(instr_ready), .instr_valid(instr_valid),
    .instr_byte(instr_byte));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 250 MHz
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Verdict and end of run
  task automatic complete_run;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      fail_count++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Stream a program, wait until drained, then compare acc, row and column
  task automatic step(input prog_t p, input logic [3:0] a, input logic [2:0] r,
                      input logic [3:0] c);
    int n;
    foreach (p[i]) SEQ.q.push_back(p[i]);
    // Look on the falling edge: at the rising edge the sequencer's own update
    // races this loop and could end the wait before the last byte is taken
    for (n = 0; n < 300; n++) begin
      @(negedge clock);
      if (SEQ.q.size() == 0 && instr_valid === 1'b0) break;
    end
    if (n == 300) begin
      fail_count++;
      complete_run();
    end
    `CHK(acc_r, a)
    `CHK(pointer_row_r, r)
    `CHK(pointer_column_r, c)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Loads, stores, pointer set and transfers
  task automatic s_load_store;
    step('{8'h15, 8'h5a}, 4'h0, 3'h5, 4'ha);
    step('{8'h97, 8'h02, 8'h83, 8'h95, 8'h99, 8'h02, 8'h90, 8'h38},
         4'h5, 3'h0, 4'h3);
    step('{8'h15, 8'h5a, 8'h3b}, 4'h7, 3'h6, 4'ha);
    step('{8'h9b, 8'h8e, 8'h12}, 4'he, 3'h0, 4'he);
    step('{8'h9d, 8'h0b, 8'h07}, 4'hd, 3'h0, 4'hd);
  endtask

  // Exchanges with column stepping, wrap skips and row flips
  task automatic s_swap;
    step('{8'h15, 8'h50, 8'h94, 8'h02, 8'h15, 8'h5f, 8'h91, 8'h02, 8'h92, 8'h3c, 8'h9f,
           8'h2c, 8'h9e}, 4'h4, 3'h5, 4'hf);
    step('{8'h38}, 4'h2, 3'h5, 4'hf);
    step('{8'h15, 8'h4f, 8'h96, 8'h02, 8'h15, 8'h5f, 8'h93, 8'h29, 8'h3e, 8'h9f},
         4'h6, 3'h6, 4'h0);
    step('{8'h95, 8'h02, 8'h9a, 8'h2f, 8'h9f}, 4'h5, 3'h5, 4'hf);
    step('{8'h94, 8'h28, 8'h38}, 4'h4, 3'h5, 4'hf);
  endtask

  // Adds with and without carry, decimal adjust, logic and acc group
  task automatic s_arith;
    step('{8'h0b, 8'h9c, 8'h08, 8'h97}, 4'h0, 3'h5, 4'hf);
    `CHK(carry_r, 1'b0)
    step('{8'h1b, 8'h9b, 8'h19, 8'h96}, 4'h6, 3'h5, 4'hf);
    `CHK(carry_r, 1'b1)
    step('{8'h1b, 8'h9b, 8'h09, 8'h97}, 4'h0, 3'h5, 4'hf);
    step('{8'h0b, 8'h9b, 8'h09, 8'h97}, 4'h7, 3'h5, 4'hf);
    `CHK(carry_r, 1'b0)
    step('{8'h0b, 8'h91, 8'h06}, 4'h7, 3'h5, 4'hf);
    step('{8'h0a}, 4'h1, 3'h5, 4'hf);
    step('{8'h18}, 4'h5, 3'h5, 4'hf);
    step('{8'h10}, 4'ha, 3'h5, 4'hf);
    step('{8'h11}, 4'h6, 3'h5, 4'hf);
    step('{8'h92, 8'h90}, 4'h2, 3'h5, 4'hf);
  endtask

  // Skips with a slow sequencer, so a pending skip spans idle cycles
  task automatic s_skips;
    SEQ.gap = 2;
    step('{8'h1b, 8'h93, 8'h1b, 8'h04, 8'h95}, 4'h3, 3'h5, 4'hf);
    step('{8'h0b, 8'h04, 8'h95}, 4'h5, 3'h5, 4'hf);
    step('{8'h0b, 8'h9f, 8'h0b, 8'h0d, 8'h91}, 4'h0, 3'h5, 4'hf);
    step('{8'h0f, 8'h92}, 4'hf, 3'h5, 4'hf);
    step('{8'h0b, 8'h8f, 8'h0b, 8'h33, 8'h15, 8'h9c, 8'h91},
         4'h1, 3'h0, 4'h0);
    step('{8'h0b, 8'h0b, 8'h13, 8'h9a}, 4'h1, 3'h0, 4'hf);
    SEQ.gap = 0;
  endtask

  // Register access: run enable, read-only state, unmapped offset
  task automatic s_regs;
    apb(1'b0, `REG_CTRL, 32'h0);
    `CHK(rd, 32'h1)
    `CHK(er, 1'b0)
    apb(1'b1, `REG_CTRL, 32'h0);
    SEQ.q.push_back(8'h0b);
    SEQ.q.push_back(8'h97);
    repeat (6) @(posedge clock);
    `CHK(instr_ready, 1'b0)
    `CHK(acc_r, 4'h1)
    apb(1'b1, `REG_CTRL, 32'h1);
    step('{8'h9e}, 4'h7, 3'h0, 4'hf);
    apb(1'b1, `REG_STATE, 32'hffffffff);
    apb(1'b0, `REG_STATE, 32'h0);
    // Run-load flag is up after the ignored load; no operand wait, no skip pending
    `CHK(rd & 32'h00077f1f, 32'h00010f07)
    apb(1'b1, 12'h008, 32'h0);
    `CHK(er, 1'b1)
    apb(1'b0, 12'h008, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(er, 1'b1)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset, then the scenarios in turn
  initial begin
    rst_b   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    s_load_store();
    s_swap();
    s_arith();
    s_skips();
    s_regs();
    complete_run();
  end
endmodule
